// ==== src/vdc_pkg.sv ====
// Shared constants and types of the decoder control and debug block
package vdc_pkg;

	// ------------------------------------------------------------
	// Bus geometry
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ERR_W = 6;
	localparam int unsigned IC_WORDS = 6;
	localparam logic [2:0] IC_LAST = 3'h5;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Register byte offsets on the configuration bus
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_EXE = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_FMT = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_STAT = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_ERR = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_EMU = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_IC0 = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_ICN = 8'h28;

	// ------------------------------------------------------------
	// Execution commands, low byte of execution_command_reg
	// ------------------------------------------------------------
	localparam logic [2:0] CMD_START = 3'h1;
	localparam logic [2:0] CMD_PAUSE = 3'h2;
	localparam logic [2:0] CMD_RESTART = 3'h3;
	localparam logic [2:0] CMD_RESTART_STEP = 3'h4;
	localparam logic [2:0] CMD_SOFT_RESET = 3'h5;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int unsigned FMT_SD_NATIVE = 0;
	localparam int unsigned FMT_BM_NATIVE = 1;
	localparam int unsigned FMT_SLEEP_A = 4;
	localparam int unsigned FMT_SLEEP_B = 5;
	localparam int unsigned STAT_PAUSE = 0;
	localparam int unsigned STAT_RUN = 1;
	localparam int unsigned STAT_ERR = 2;
	localparam int unsigned STAT_WIC = 3;
	localparam int unsigned STAT_EMUHALT = 4;
	localparam int unsigned EMU_DEBUG_EN = 0;
	localparam int unsigned EMU_HALT_MODE = 1;
	localparam int unsigned IC3_OUT_DESC = 0;
	localparam int unsigned IC5_SOFT = 0;
	localparam int unsigned IC5_OUTPARAM_EVENT_FLAG = 1;
	localparam int unsigned IC5_TB_LSB = 4;
	localparam logic [7:0] POLY_UNUSED = 8'h00;
	localparam logic [7:0] FMT_RESET = 8'h00;
	localparam logic [1:0] EMU_RESET = 2'h0;

	// Traceback modes, in field order
	typedef enum logic [1:0] {
		TB_CONVERGENT,
		TB_MIXED,
		TB_TAILED,
		TB_NONE
	} vdc_tb_e;

	// Fields decoded from the six configuration words
	typedef struct packed {
		logic [3:0][7:0] poly;
		logic [3:0] poly_used;
		logic [15:0] sm_max;
		logic [15:0] sm_min;
		logic [7:0] sm_state;
		logic out_desc;
		logic soft_dec;
		logic outparam_evt_en;
		vdc_tb_e tb_mode;
	} vdc_cfg_s;

	// Status word zero contents
	typedef struct packed {
		logic emu_halt;
		logic waiting_for_config;
		logic err;
		logic run;
		logic pause;
	} vdc_stat_s;

endpackage : vdc_pkg

// ==== src/vdc_ctrl.sv ====
// Control, status and debug logic of the decoder coprocessor
//
// Contract
// - Single step while paused restarts current traceback, pauses at the next one.
// - Soft reset clears registers except execution, format/sleep and emulation control.
// - Reading error flags clears the error-pending bit in status word zero.
// - Error flags hold six separate error conditions.
// - Status word zero debug-halt bit is 1 only after an emulation halt.
// - Sleep bit for domain A: 0 disables sleep, 1 gives internal control.
// - Independent sleep bit for domain B behaves the same way.
// - Both sleep bits live in format/sleep register and read back as written.
// - Halt mode 0 halts at window or frame end; mode 1 at frame end.
// - Disabling debug mode returns to normal operation with no emulation halts.
// - Six 32-bit configuration words arrive over DMA before decoding proceeds.
// - Two register ports: configuration bus and DMA data bus.
// - Output-parameters read event raised only when its configuration field is set.
// - Output bit order field selects ascending or descending packing.
// - Decision type field selects hard or soft decisions.
// - Soft decision memory format is native 8-bit or packed 32-bit.
// - Traceback mode field offers convergent, mixed, tailed and none.
// - Execution register accepts plain restart and restart-one-window-then-pause; the step pauses at the next traceback end instead.
// - Four 8-bit generator polynomials; zero marks a polynomial unused.
// - Initial metrics: maximum at programmed state index, minimum elsewhere.
// - Plain resume restarts current traceback and runs to completion.
// - Error pauses decoder and sets error-pending bit.
// - Status word zero shows when decoder waits for configuration words.
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ns
module vdc_ctrl import vdc_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic dma_wvalid,
	input wire logic [DATA_W-1:0] dma_wdata,
	output logic dma_wready,
	input wire logic core_window_done,
	input wire logic core_tb_done,
	input wire logic core_frame_done,
	input wire logic [ERR_W-1:0] core_err,
	input wire logic emu_halt_req,
	output logic core_run,
	output logic core_restart_tb,
	output logic outparam_evt,
	output logic sleep_domain_a,
	output logic sleep_domain_b,
	output logic sd_native,
	output logic bm_native,
	output vdc_cfg_s cfg,
	input wire logic [7:0] sm_query_idx,
	output logic [15:0] sm_query_val
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT_CFG,
		ST_RUN,
		ST_PAUSED,
		ST_HALTED
	} vdc_state_e;

	vdc_state_e state, next_state;
	logic step, next_step;
	logic halt_eof, next_halt_eof;
	logic [7:0] fmt, next_fmt;
	logic [1:0] emu, next_emu;
	logic [ERR_W-1:0] err_flags, next_err_flags;
	vdc_stat_s stat, next_stat;
	logic [IC_WORDS-1:0][DATA_W-1:0] ic, next_ic;
	logic [2:0] ic_cnt, next_ic_cnt;
	logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [DATA_W-1:0] next_rdata;
	logic next_dma_wready, next_core_run, next_restart_tb, next_outparam_evt;
	vdc_cfg_s next_cfg;
	logic [15:0] next_sm_query_val;

	// Bus strobes
	logic wr_en, rd_en, dma_take;
	logic [2:0] cmd;
	logic cmd_valid, debug_en, halt_now;
	logic [ADDR_W-1:0] ic_off;

	// Merge a write under its byte enables
	function automatic logic [DATA_W-1:0] merge(
		input logic [DATA_W-1:0] old,
		input logic [DATA_W-1:0] data,
		input logic [3:0] strb
	);
		logic [DATA_W-1:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	// ------------------------------------------------------------
	// Bus handshakes and command decode
	// ------------------------------------------------------------
	// Write taken when both address and data have been offered
	assign wr_en = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
	assign rd_en = s_axi_arready && s_axi_arvalid;
	assign dma_take = dma_wready && dma_wvalid;
	assign cmd = s_axi_wdata[2:0];
	assign cmd_valid = wr_en && (s_axi_awaddr == OFF_EXE) && s_axi_wstrb[0];
	assign debug_en = emu[EMU_DEBUG_EN];
	// Halt point depends on halt mode; no halts with debug off
	assign halt_now = debug_en && emu_halt_req && (core_frame_done
		|| (!emu[EMU_HALT_MODE] && core_window_done));

	// AXI channel handshakes
	always_comb begin
		next_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
		next_wready = next_awready;
		next_bvalid = s_axi_bvalid && !s_axi_bready;
		next_bresp = s_axi_bresp;
		if (wr_en) begin
			next_bvalid = 1'b1;
			next_bresp = RESP_OKAY;
			if (s_axi_awaddr > OFF_ICN || s_axi_awaddr[1:0] != 2'h0) begin
				next_bresp = RESP_SLVERR;
			end
		end
		next_arready = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
		next_rvalid = s_axi_rvalid && !s_axi_rready;
		if (rd_en) begin
			next_rvalid = 1'b1;
		end
	end

	// Read data mux
	always_comb begin
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		ic_off = s_axi_araddr - OFF_IC0;
		if (rd_en) begin
			next_rdata = '0;
			next_rresp = RESP_OKAY;
			case (s_axi_araddr)
				OFF_EXE: next_rdata = '0;
				OFF_FMT: next_rdata[7:0] = fmt;
				OFF_STAT: next_rdata[4:0] = stat;
				OFF_ERR: next_rdata[ERR_W-1:0] = err_flags;
				OFF_EMU: next_rdata[1:0] = emu;
				default: begin
					if (s_axi_araddr >= OFF_IC0 && s_axi_araddr <= OFF_ICN
						&& s_axi_araddr[1:0] == 2'h0) begin
						next_rdata = ic[ic_off[4:2]];
					end else begin
						next_rresp = RESP_SLVERR;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Register file and sequencer
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_step = step;
		next_halt_eof = halt_eof;
		next_fmt = fmt;
		next_emu = emu;
		next_err_flags = err_flags;
		next_stat = stat;
		next_ic = ic;
		next_ic_cnt = ic_cnt;
		next_restart_tb = 1'b0;
		next_outparam_evt = 1'b0;
		// Host writes to the kept registers
		if (wr_en && s_axi_awaddr == OFF_FMT && s_axi_wstrb[0]) begin
			next_fmt = s_axi_wdata[7:0];
		end
		if (wr_en && s_axi_awaddr == OFF_EMU && s_axi_wstrb[0]) begin
			next_emu = s_axi_wdata[1:0];
		end
		// Error flags read clears them; a same-cycle error still sets
		if (rd_en && s_axi_araddr == OFF_ERR) begin
			next_err_flags = '0;
			next_stat.err = 1'b0;
		end
		// Configuration words over the DMA port
		if (dma_take) begin
			next_ic[ic_cnt] = dma_wdata;
			next_ic_cnt = ic_cnt + 3'h1;
		end
		// Host may also patch a configuration word directly
		if (wr_en && s_axi_awaddr >= OFF_IC0 && s_axi_awaddr <= OFF_ICN
			&& s_axi_awaddr[1:0] == 2'h0) begin
			next_ic[ic_off_w()] = merge(ic[ic_off_w()], s_axi_wdata, s_axi_wstrb);
		end
		case (state)
			ST_IDLE: begin
				if (cmd_valid && cmd == CMD_START) begin
					next_state = ST_WAIT_CFG;
					next_ic_cnt = '0;
				end
			end
			ST_WAIT_CFG: begin
				// Decoding waits for all six words
				if (dma_take && ic_cnt == IC_LAST) begin
					next_state = ST_RUN;
					next_step = 1'b0;
				end
			end
			ST_RUN: begin
				if (|core_err) begin
					next_state = ST_PAUSED;
					next_stat.err = 1'b1;
					// A read clearing the flags in this cycle lets the new error in
					if (!stat.err || (rd_en && s_axi_araddr == OFF_ERR)) begin
						next_err_flags = core_err;
					end
				end else if (halt_now) begin
					next_state = ST_HALTED;
					next_halt_eof = core_frame_done;
					next_stat.emu_halt = 1'b1;
					next_outparam_evt = core_frame_done && cfg.outparam_evt_en;
				end else if (core_frame_done) begin
					next_state = ST_IDLE;
					next_outparam_evt = cfg.outparam_evt_en;
				end else if (step && core_tb_done) begin
					next_state = ST_PAUSED;
					next_step = 1'b0;
				end else if (cmd_valid && cmd == CMD_PAUSE && debug_en) begin
					next_state = ST_PAUSED;
				end
			end
			ST_PAUSED: begin
				if (cmd_valid && cmd == CMD_RESTART) begin
					next_state = ST_RUN;
					next_step = 1'b0;
					next_restart_tb = 1'b1;
				end else if (cmd_valid && cmd == CMD_RESTART_STEP) begin
					next_state = ST_RUN;
					next_step = 1'b1;
					next_restart_tb = 1'b1;
				end
			end
			ST_HALTED: begin
				// Leave on release of the halt or on debug disable
				if (!emu_halt_req || !debug_en) begin
					next_stat.emu_halt = 1'b0;
					next_state = halt_eof ? ST_IDLE : ST_RUN;
					next_restart_tb = !halt_eof;
				end
			end
			default: next_state = ST_IDLE;
		endcase
		// Soft reset spares execution, format/sleep and emulation state
		if (cmd_valid && cmd == CMD_SOFT_RESET) begin
			next_ic = '0;
			next_ic_cnt = '0;
			next_err_flags = '0;
			next_stat.err = 1'b0;
		end
		next_stat.pause = (next_state == ST_PAUSED);
		next_stat.run = (next_state == ST_RUN);
		next_stat.waiting_for_config = (next_state == ST_WAIT_CFG);
	end

	// Word index of a configuration write
	function automatic logic [2:0] ic_off_w();
		logic [ADDR_W-1:0] o;
		o = s_axi_awaddr - OFF_IC0;
		return o[4:2];
	endfunction : ic_off_w

	// ------------------------------------------------------------
	// Decoded configuration and port outputs
	// ------------------------------------------------------------
	always_comb begin
		next_cfg.poly = next_ic[0];
		for (int p = 0; p < 4; p++) begin
			next_cfg.poly_used[p] = (next_ic[0][p*8 +: 8] != POLY_UNUSED);
		end
		next_cfg.sm_max = next_ic[1][15:0];
		next_cfg.sm_min = next_ic[1][31:16];
		next_cfg.sm_state = next_ic[2][7:0];
		next_cfg.out_desc = next_ic[3][IC3_OUT_DESC];
		next_cfg.soft_dec = next_ic[5][IC5_SOFT];
		next_cfg.outparam_evt_en = next_ic[5][IC5_OUTPARAM_EVENT_FLAG];
		next_cfg.tb_mode = vdc_tb_e'(next_ic[5][IC5_TB_LSB +: 2]);
		// Maximum metric only at the programmed state
		next_sm_query_val = (sm_query_idx == cfg.sm_state) ? cfg.sm_max : cfg.sm_min;
		next_dma_wready = (next_state == ST_WAIT_CFG);
		next_core_run = (next_state == ST_RUN);
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			step <= 1'b0;
			halt_eof <= 1'b0;
			fmt <= FMT_RESET;
			emu <= EMU_RESET;
			err_flags <= '0;
			stat <= '0;
			ic <= '0;
			ic_cnt <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rdata <= '0;
			dma_wready <= 1'b0;
			core_run <= 1'b0;
			core_restart_tb <= 1'b0;
			outparam_evt <= 1'b0;
			sleep_domain_a <= 1'b0;
			sleep_domain_b <= 1'b0;
			sd_native <= 1'b0;
			bm_native <= 1'b0;
			cfg <= '0;
			sm_query_val <= '0;
		end else if (ce) begin
			state <= next_state;
			step <= next_step;
			halt_eof <= next_halt_eof;
			fmt <= next_fmt;
			emu <= next_emu;
			err_flags <= next_err_flags;
			stat <= next_stat;
			ic <= next_ic;
			ic_cnt <= next_ic_cnt;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rresp <= next_rresp;
			s_axi_rdata <= next_rdata;
			dma_wready <= next_dma_wready;
			core_run <= next_core_run;
			core_restart_tb <= next_restart_tb;
			outparam_evt <= next_outparam_evt;
			sleep_domain_a <= next_fmt[FMT_SLEEP_A];
			sleep_domain_b <= next_fmt[FMT_SLEEP_B];
			sd_native <= next_fmt[FMT_SD_NATIVE];
			bm_native <= next_fmt[FMT_BM_NATIVE];
			cfg <= next_cfg;
			sm_query_val <= next_sm_query_val;
		end
	end

endmodule : vdc_ctrl

// ==== tb/vdc_core_model.sv ====
// Trellis core stand-in driven by the control block's run and restart
`timescale 1ns/1ns
module vdc_core_model #(parameter int FRAME = 600) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire logic restart,
	input wire logic [5:0] err_req,
	output logic win_done,
	output logic tb_done,
	output logic frame_done,
	output logic [5:0] err
);
	logic [9:0] pos;
	// Frame progress only while told to run; restart goes back to traceback start
	always_ff @(posedge aclk) begin
		if (!aresetn || frame_done) pos <= 10'h000;
		else if (restart) pos <= {pos[9:4], 4'h0};
		else if (run) pos <= pos + 10'h001;
	end
	// Window, traceback and frame ends as one-cycle pulses
	assign win_done = run && pos[2:0] == 3'h7;
	assign tb_done = run && pos[3:0] == 4'hF;
	assign frame_done = run && pos == 10'(FRAME - 1);
	assign err = err_req;
endmodule : vdc_core_model

// ==== tb/vdc_ctrl_props.sv ====
// Concurrent checks on the control block ports
`timescale 1ns/1ns
module vdc_ctrl_props import vdc_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [DATA_W-1:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [ERR_W-1:0] core_err,
	input wire logic core_run,
	input wire logic core_restart_tb,
	input wire logic outparam_evt,
	input wire logic sleep_domain_a,
	input wire vdc_cfg_s cfg
);
	// ------------------------------------------------------------
	// Bus and sequencer relations
	// ------------------------------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	aw_w_pair_a: assert property (s_axi_awready |-> s_axi_wready)
		else $error("address taken without data");
	write_answer_a: assert property (s_axi_awready && s_axi_awvalid && s_axi_wvalid
		|=> s_axi_bvalid)
		else $error("no write response after take");
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	read_answer_a: assert property (s_axi_arready && s_axi_arvalid |=> s_axi_rvalid)
		else $error("no read data after take");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	evt_gate_a: assert property (outparam_evt |-> cfg.outparam_evt_en)
		else $error("read event while disabled");
	sleep_write_a: assert property ($changed(sleep_domain_a) |-> $past(s_axi_awready)
		&& $past(s_axi_awvalid) && $past(s_axi_awaddr) == OFF_FMT)
		else $error("sleep bit moved without a write");
	err_pause_a: assert property (core_run && |core_err |-> ##[1:2] !core_run)
		else $error("error did not stop the decoder");
	restart_run_a: assert property (core_restart_tb |-> ##[0:2] core_run)
		else $error("restart pulse without run");
endmodule : vdc_ctrl_props
bind vdc_ctrl vdc_ctrl_props chk_u (.*);

// ==== tb/vdc_ctrl_tb_top.sv ====
// Directed bench for the decoder control block
`timescale 1ns/1ns
module vdc_ctrl_tb_top import vdc_pkg::*;;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic ce = 1'h1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, sm_query_idx = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, dma_wdata = 32'h0, rd, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0, dma_wvalid = 1'h0;
	logic s_axi_bready = 1'h1, s_axi_rready = 1'h1, emu_halt_req = 1'h0;
	logic [5:0] ereq = 6'h00, core_err;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, dma_wready;
	logic core_window_done, core_tb_done, core_frame_done, core_run, core_restart_tb;
	logic outparam_evt, sleep_domain_a, sleep_domain_b, sd_native, bm_native;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic [15:0] sm_query_val;
	vdc_cfg_s cfg;
	int bad_count = 0, checks_done = 0, cyc = 0, evt_n = 0, rst_n = 0;

	always #2 aclk = ~aclk;
	vdc_ctrl dut_u (.*);
	vdc_core_model #(.FRAME(600)) core_u (.aclk(aclk), .aresetn(aresetn), .run(core_run),
		.restart(core_restart_tb), .err_req(ereq), .win_done(core_window_done),
		.tb_done(core_tb_done), .frame_done(core_frame_done), .err(core_err));

	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	// Optional hold keeps the response ready low until that many cycles after the response arrives
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input int hold = 0);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= (hold == 0);
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1 && n < 50);
		if (hold > 0) begin
			repeat (hold) @(posedge aclk);
			s_axi_bready <= 1'h1;
			@(posedge aclk);
		end
		chk("bresp", 32'h0, {29'h0, !s_axi_bvalid, s_axi_bresp});
	endtask : axw
	task automatic axr(input logic [7:0] a, input int hold = 0);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= (hold == 0);
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1 && n < 50);
		chk("rvalid", 32'h1, 32'(s_axi_rvalid));
		if (hold > 0) begin
			repeat (hold) @(posedge aclk);
			s_axi_rready <= 1'h1;
			@(posedge aclk);
		end
		rd = s_axi_rdata;
		rr = s_axi_rresp;
	endtask : axr
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		axr(a);
		chk(nm, exp, rd);
	endtask : rchk
	task automatic waitst(input int b, input logic v);
		int n;
		n = 0;
		do begin
			axr(OFF_STAT);
			n++;
		end while (rd[b] !== v && n < 60);
		chk("status", 32'(v), 32'(rd[b]));
	endtask : waitst
	task automatic inj(input logic [5:0] v);
		waitst(STAT_RUN, 1'h1);
		ereq <= v;
		@(posedge aclk);
		ereq <= 6'h00;
		waitst(STAT_ERR, 1'h1);
	endtask : inj
	task automatic start_cfg(input logic [31:0] w5);
		logic [31:0] w [6];
		int n;
		w = '{32'h00B0F030, 32'hFF800123, 32'h5, 32'h1, 32'h0, w5};
		axw(OFF_EXE, 32'(CMD_START));
		waitst(STAT_WIC, 1'h1);
		for (int k = 0; k < 6; k++) begin
			dma_wvalid <= 1'h1;
			dma_wdata <= w[k];
			n = 0;
			do begin
				@(posedge aclk);
				n++;
			end while (dma_wready !== 1'h1 && n < 20);
		end
		dma_wvalid <= 1'h0;
		waitst(STAT_RUN, 1'h1);
	endtask : start_cfg

	// Cycle limit and event counters
	always @(posedge aclk) begin
		cyc++;
		if (outparam_evt === 1'h1) evt_n++;
		if (core_restart_tb === 1'h1) rst_n++;
		if (cyc == 20000) begin
			bad_count++;
			close_out();
		end
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		int n;
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		rchk("fmt", OFF_FMT, 32'h0);
		rchk("emu", OFF_EMU, 32'h0);
		rchk("stat", OFF_STAT, 32'h0);
		axr(8'h40);
		chk("unmapped", 32'h2, 32'(rr) | rd);
		axw(OFF_FMT, 32'h21);
		rchk("fmt", OFF_FMT, 32'h21);
		axr(OFF_FMT, 3);
		chk("fmt held", 32'h21, rd);
		chk("pins", 32'h6, {28'h0, sleep_domain_a, sleep_domain_b, sd_native, bm_native});
		axw(OFF_FMT, 32'h12, 2);
		chk("pins", 32'h9, {28'h0, sleep_domain_a, sleep_domain_b, sd_native, bm_native});
		axw(OFF_EMU, 32'h1);
		start_cfg(32'h23);
		chk("poly", 32'h00B0F030, cfg.poly);
		chk("used", 32'h7, 32'(cfg.poly_used));
		chk("order", 32'h1, 32'(cfg.out_desc));
		chk("ic5", 32'hE, 32'({cfg.outparam_evt_en, cfg.soft_dec, cfg.tb_mode}));
		sm_query_idx <= 8'h05;
		repeat (2) @(posedge aclk);
		chk("smax", 32'h0123, 32'(sm_query_val));
		sm_query_idx <= 8'h06;
		repeat (2) @(posedge aclk);
		chk("smin", 32'hFF80, 32'(sm_query_val));
		n = 0;
		while (evt_n == 0 && n < 900) begin
			@(posedge aclk);
			n++;
		end
		chk("event", 32'h1, 32'(evt_n));
		for (int m = 0; m < 4; m++) begin
			axw(OFF_ICN, 32'(m) << IC5_TB_LSB);
			chk("tbmode", 32'(m), 32'(cfg.tb_mode));
		end
		start_cfg(32'h0);
		axw(OFF_EXE, 32'(CMD_PAUSE));
		waitst(STAT_PAUSE, 1'h1);
		n = rst_n;
		axw(OFF_EXE, 32'(CMD_RESTART_STEP));
		axr(OFF_STAT);
		chk("step run", 32'h1, 32'(rd[STAT_RUN]));
		waitst(STAT_PAUSE, 1'h1);
		chk("restarts", 32'(n + 1), 32'(rst_n));
		axw(OFF_EXE, 32'(CMD_RESTART));
		repeat (40) @(posedge aclk);
		axr(OFF_STAT);
		chk("resumed", 32'h1, 32'(rd[STAT_RUN]));
		for (int k = 0; k < 6; k++) begin
			inj(6'h01 << k);
			rchk("flags", OFF_ERR, 32'h1 << k);
			axr(OFF_STAT);
			chk("errbit", 32'h0, 32'(rd[STAT_ERR]));
			axw(OFF_EXE, 32'(CMD_RESTART));
		end
		inj(6'h09);
		axw(OFF_EXE, 32'(CMD_RESTART));
		inj(6'h02);
		rchk("kept", OFF_ERR, 32'h09);
		axw(OFF_ICN, 32'hA5);
		axw(OFF_EXE, 32'(CMD_SOFT_RESET));
		rchk("ic5", OFF_ICN, 32'h0);
		rchk("fmt", OFF_FMT, 32'h12);
		rchk("emu", OFF_EMU, 32'h1);
		axw(OFF_EXE, 32'(CMD_RESTART));
		waitst(STAT_RUN, 1'h1);
		emu_halt_req <= 1'h1;
		waitst(STAT_EMUHALT, 1'h1);
		chk("halted", 32'h0, 32'(rd[STAT_RUN]));
		emu_halt_req <= 1'h0;
		waitst(STAT_EMUHALT, 1'h0);
		axw(OFF_EMU, 32'h3);
		emu_halt_req <= 1'h1;
		repeat (20) @(posedge aclk);
		axr(OFF_STAT);
		chk("mode1", 32'h2, 32'(rd[4:0]) & 32'h12);
		axw(OFF_EMU, 32'h0);
		repeat (20) @(posedge aclk);
		axr(OFF_STAT);
		chk("nodebug", 32'h2, 32'(rd[4:0]) & 32'h12);
		emu_halt_req <= 1'h0;
		close_out();
	end
endmodule : vdc_ctrl_tb_top
